// ===== dmr_host_model.sv
// Host audio processor on the far side of the audio interface.
// Sends receive pairs on command from the bench, captures transmit pairs.
`timescale 1ns/10ps
module dmr_host_model #(
	parameter int W = 24
) (
	// Clock and reset
	input wire logic			pclk,
	input wire logic			presetn,
	// Commands from the bench
	input wire logic			send,
	input wire logic signed [W-1:0]	l_in,
	input wire logic signed [W-1:0]	r_in,
	// Receive channels toward the core
	output logic				rx_valid,
	output logic signed [W-1:0]		rx_left,
	output logic signed [W-1:0]		rx_right,
	// Transmit channels from the core
	input wire logic			tx_valid,
	input wire logic signed [W-1:0]	tx_left,
	input wire logic signed [W-1:0]	tx_right,
	output logic [2*W-1:0]		got
);
	// One-beat pair; data toggles between beats so stale values never match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_valid <= 1'b0;
			rx_left <= '0;
			rx_right <= '0;
		end else begin
			rx_valid <= send;
			rx_left <= send ? l_in : ~rx_left;
			rx_right <= send ? r_in : ~rx_right;
		end
	end
	// Capture each transmit pair
	always_ff @(posedge pclk) begin
		if (tx_valid) got <= {tx_left, tx_right};
	end
endmodule // dmr_host_model

// ===== dmr_mix_router.sv
// Digital mixing and routing core: microphone to transmit routing,
// receive to converter routing, boost, polarity flips and sidetone.
// Assumes samples synchronous to pclk, each with a one-cycle valid.
//
// The APB register port was decided locally.
`timescale 1ns/10ps
module dmr_mix_router #(
	parameter int W = dmr_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [dmr_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Raw microphone samples for transmit
	input  wire logic                        mic_valid,
	input  wire logic signed [W-1:0]         mic_left,
	input  wire logic signed [W-1:0]         mic_right,
	// High-pass filtered microphone samples for sidetone
	input  wire logic                        hpf_valid,
	input  wire logic signed [W-1:0]         hpf_left,
	input  wire logic signed [W-1:0]         hpf_right,
	// Transmit channels to the audio interface
	output logic                             tx_valid,
	output logic signed [W-1:0]              tx_left,
	output logic signed [W-1:0]              tx_right,
	// Receive channels from the audio interface
	input  wire logic                        rx_valid,
	input  wire logic signed [W-1:0]         rx_left,
	input  wire logic signed [W-1:0]         rx_right,
	// Converter inputs
	output logic                             dac_valid,
	output logic signed [W-1:0]              dac_left,
	output logic signed [W-1:0]              dac_right
);

	logic [dmr_pkg::REG_W-1:0] interface_route_control;
	logic [dmr_pkg::REG_W-1:0] sidetone_control;
	logic [dmr_pkg::REG_W-1:0] mic_polarity_control;
	logic [1:0]                clip_status;
	logic                      wr_en;
	logic                      rd_hit;
	logic                      clear_clip;
	logic signed [W-1:0]       mic_l_pol;
	logic signed [W-1:0]       mic_r_pol;
	logic signed [W-1:0]       st_hold_l;
	logic signed [W-1:0]       st_hold_r;
	logic signed [W-1:0]       rx_pick_l;
	logic signed [W-1:0]       rx_pick_r;
	logic signed [W-1:0]       rx_pol_l;
	logic signed [W-1:0]       rx_pol_r;
	logic signed [W-1:0]       tone_l;
	logic signed [W-1:0]       tone_r;
	logic signed [W+4:0]       sum_l;
	logic signed [W+4:0]       sum_r;
	logic signed [W-1:0]       next_dac_left;
	logic signed [W-1:0]       next_dac_right;
	logic                      clip_l;
	logic                      clip_r;
	logic [1:0]                boost;

	// ==========================================================
	// APB slave: no wait states, error on unmapped addresses
	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite;

	always_comb begin
		rd_hit = 1'b1;
		prdata = 32'h0000_0000;
		unique case (paddr)
			dmr_pkg::ADDR_ROUTE:    prdata[dmr_pkg::REG_W-1:0] = interface_route_control;
			dmr_pkg::ADDR_SIDETONE: prdata[dmr_pkg::REG_W-1:0] = sidetone_control;
			dmr_pkg::ADDR_MICPOL:   prdata[dmr_pkg::REG_W-1:0] = mic_polarity_control;
			dmr_pkg::ADDR_STATUS:   prdata[1:0] = clip_status;
			default:                rd_hit = 1'b0;
		endcase
	end

	assign pslverr = psel && penable && !rd_hit;

	// Routing register; unused bits stay zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interface_route_control <= dmr_pkg::ROUTE_RESET;
		end else if (wr_en && paddr == dmr_pkg::ADDR_ROUTE) begin
			interface_route_control <= pwdata[dmr_pkg::REG_W-1:0] & dmr_pkg::ROUTE_MASK;
		end
	end

	// Sidetone register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sidetone_control <= dmr_pkg::SIDETONE_RESET;
		end else if (wr_en && paddr == dmr_pkg::ADDR_SIDETONE) begin
			sidetone_control <= pwdata[dmr_pkg::REG_W-1:0] & dmr_pkg::SIDETONE_MASK;
		end
	end

	// Microphone polarity register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mic_polarity_control <= dmr_pkg::MICPOL_RESET;
		end else if (wr_en && paddr == dmr_pkg::ADDR_MICPOL) begin
			mic_polarity_control <= pwdata[dmr_pkg::REG_W-1:0] & dmr_pkg::MICPOL_MASK;
		end
	end

	// Sticky clip flags, write one to clear; a new clip wins the clear
	assign clear_clip = wr_en && paddr == dmr_pkg::ADDR_STATUS;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clip_status <= dmr_pkg::STATUS_RESET;
		end else begin
			clip_status[dmr_pkg::STAT_CLIP_L] <= (rx_valid && clip_l) ||
				(clip_status[dmr_pkg::STAT_CLIP_L] &&
				 !(clear_clip && pwdata[dmr_pkg::STAT_CLIP_L]));
			clip_status[dmr_pkg::STAT_CLIP_R] <= (rx_valid && clip_r) ||
				(clip_status[dmr_pkg::STAT_CLIP_R] &&
				 !(clear_clip && pwdata[dmr_pkg::STAT_CLIP_R]));
		end
	end

	// ==========================================================
	// Transmit path: flip each mic, then pick per channel
	dmr_sat_negate #(.W(W)) u_mic_pol_l (
		.din  (mic_left),
		.flip (mic_polarity_control[dmr_pkg::MIC_INV_L]),
		.dout (mic_l_pol)
	);

	dmr_sat_negate #(.W(W)) u_mic_pol_r (
		.din  (mic_right),
		.flip (mic_polarity_control[dmr_pkg::MIC_INV_R]),
		.dout (mic_r_pol)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_valid <= 1'b0;
			tx_left  <= '0;
			tx_right <= '0;
		end else begin
			tx_valid <= mic_valid;
			if (mic_valid) begin
				tx_left  <= interface_route_control[dmr_pkg::ROUTE_TXL_SRC] ?
					mic_r_pol : mic_l_pol;
				tx_right <= interface_route_control[dmr_pkg::ROUTE_TXR_SRC] ?
					mic_r_pol : mic_l_pol;
			end
		end
	end

	// ==========================================================
	// Sidetone: hold the latest filtered samples between frames
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_hold_l <= '0;
			st_hold_r <= '0;
		end else if (hpf_valid) begin
			st_hold_l <= hpf_left;
			st_hold_r <= hpf_right;
		end
	end

	dmr_sidetone_scale #(.W(W)) u_tone_l (
		.hpf_left  (st_hold_l),
		.hpf_right (st_hold_r),
		.source    (sidetone_control[dmr_pkg::ST_SRC_L_LO+:2]),
		.level     (sidetone_control[dmr_pkg::ST_LVL_L_LO+:4]),
		.tone      (tone_l)
	);

	dmr_sidetone_scale #(.W(W)) u_tone_r (
		.hpf_left  (st_hold_l),
		.hpf_right (st_hold_r),
		.source    (sidetone_control[dmr_pkg::ST_SRC_R_LO+:2]),
		.level     (sidetone_control[dmr_pkg::ST_LVL_R_LO+:4]),
		.tone      (tone_r)
	);

	// ==========================================================
	// Receive path: pick, flip, boost, add sidetone, saturate
	assign rx_pick_l = interface_route_control[dmr_pkg::ROUTE_RXL_SRC] ?
		rx_right : rx_left;
	assign rx_pick_r = interface_route_control[dmr_pkg::ROUTE_RXR_SRC] ?
		rx_right : rx_left;

	dmr_sat_negate #(.W(W)) u_rx_pol_l (
		.din  (rx_pick_l),
		.flip (interface_route_control[dmr_pkg::ROUTE_RXL_INV]),
		.dout (rx_pol_l)
	);

	dmr_sat_negate #(.W(W)) u_rx_pol_r (
		.din  (rx_pick_r),
		.flip (interface_route_control[dmr_pkg::ROUTE_RXR_INV]),
		.dout (rx_pol_r)
	);

	assign boost = interface_route_control[dmr_pkg::ROUTE_BOOST_LO+:2];

	// Each boost step is one bit of shift, about 6 dB; wide sum never wraps
	assign sum_l = ((W+5)'(rx_pol_l) <<< boost) + (W+5)'(tone_l);
	assign sum_r = ((W+5)'(rx_pol_r) <<< boost) + (W+5)'(tone_r);

	// Clamp to signed full scale
	function automatic logic signed [W-1:0] clamp(input logic signed [W+4:0] v);
		logic signed [W+4:0] hi;
		logic signed [W+4:0] lo;
		hi = (W+5)'({1'b0, {(W-1){1'b1}}});
		lo = -hi - (W+5)'(1);
		if (v > hi) begin
			clamp = {1'b0, {(W-1){1'b1}}};
		end else if (v < lo) begin
			clamp = {1'b1, {(W-1){1'b0}}};
		end else begin
			clamp = v[W-1:0];
		end
	endfunction

	assign next_dac_left  = clamp(sum_l);
	assign next_dac_right = clamp(sum_r);
	assign clip_l = (W+5)'(next_dac_left) != sum_l;
	assign clip_r = (W+5)'(next_dac_right) != sum_r;

	// Converter outputs, one cycle after the receive strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac_valid <= 1'b0;
			dac_left  <= '0;
			dac_right <= '0;
		end else begin
			dac_valid <= rx_valid;
			if (rx_valid) begin
				dac_left  <= next_dac_left;
				dac_right <= next_dac_right;
			end
		end
	end

endmodule // dmr_mix_router

// ===== dmr_mix_router_monitor.sv
// Checker bound to the mixing and routing core top.
// Shadows APB writes to predict the transmit path, and the receive path while sidetone is off; sees ports only.
`timescale 1ns/10ps
module dmr_mix_router_monitor #(
	parameter int W = 24
) (
	// Clock and reset
	input wire logic				pclk,
	input wire logic				presetn,
	// APB
	input wire logic				psel,
	input wire logic				penable,
	input wire logic				pwrite,
	input wire logic [dmr_pkg::ADDR_W-1:0]	paddr,
	input wire logic [31:0]			pwdata,
	input wire logic				pslverr,
	// Samples in
	input wire logic				mic_valid,
	input wire logic signed [W-1:0]		mic_left,
	input wire logic signed [W-1:0]		mic_right,
	input wire logic				rx_valid,
	input wire logic signed [W-1:0]		rx_left,
	input wire logic signed [W-1:0]		rx_right,
	// Samples out
	input wire logic				tx_valid,
	input wire logic signed [W-1:0]		tx_left,
	input wire logic signed [W-1:0]		tx_right,
	input wire logic				dac_valid,
	input wire logic signed [W-1:0]		dac_left,
	input wire logic signed [W-1:0]		dac_right
);
	typedef logic signed [W-1:0] dmr_smp_t;
	logic [15:0]	rt;
	logic [15:0]	st;
	logic [1:0]	mp;
	logic		mapped;
	logic		nl;
	logic		nr;
	dmr_smp_t	el, er, dl, dr;
	// ==========
	// Helpers
	function automatic dmr_smp_t sat(input longint v);
		longint mx;
		mx = (longint'(1) <<< (W - 1)) - 1;
		if (v > mx) return dmr_smp_t'(mx);
		if (v < -mx - 1) return dmr_smp_t'(-mx - 1);
		return dmr_smp_t'(v);
	endfunction
	// Optional flip, saturated so the most negative value cannot wrap
	function automatic longint fl(input dmr_smp_t x, input logic f);
		return sat(f ? -longint'(x) : longint'(x));
	endfunction
	// Decode of the mapped addresses
	assign mapped = paddr inside {dmr_pkg::ADDR_ROUTE, dmr_pkg::ADDR_SIDETONE,
		dmr_pkg::ADDR_MICPOL, dmr_pkg::ADDR_STATUS};
	// Shadow of the control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rt <= 16'h0050;
			st <= 16'h0000;
			mp <= 2'h0;
		end else if (psel && penable && pwrite) begin
			if (paddr == dmr_pkg::ADDR_ROUTE) rt <= pwdata[15:0] & 16'h1ef0;
			if (paddr == dmr_pkg::ADDR_SIDETONE) st <= pwdata[15:0] & 16'h0fff;
			if (paddr == dmr_pkg::ADDR_MICPOL) mp <= pwdata[1:0];
		end
	end
	// Expected outputs for the sample taken at this edge
	always_ff @(posedge pclk) begin
		if (mic_valid) begin
			el <= sat(fl(rt[7] ? mic_right : mic_left, rt[7] ? mp[0] : mp[1]));
			er <= sat(fl(rt[6] ? mic_right : mic_left, rt[6] ? mp[0] : mp[1]));
		end
		if (rx_valid) begin
			dl <= sat(fl(rt[5] ? rx_right : rx_left, rt[12]) <<< rt[10:9]);
			dr <= sat(fl(rt[4] ? rx_right : rx_left, rt[11]) <<< rt[10:9]);
			nl <= st[3:2] == 2'h0 || st[3:2] == 2'h3;
			nr <= st[1:0] == 2'h0 || st[1:0] == 2'h3;
		end
	end
	// ==========
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_tx_follows: assert property (mic_valid |=> tx_valid)
		else $error("tx valid did not follow mic valid");
	chk_tx_quiet: assert property (!mic_valid |=> !tx_valid && $stable(tx_left))
		else $error("tx changed without a mic sample");
	chk_tx_left: assert property (tx_valid |-> tx_left == el)
		else $error("tx left wrong");
	chk_tx_right: assert property (tx_valid |-> tx_right == er)
		else $error("tx right wrong");
	chk_dac_follows: assert property (rx_valid |=> dac_valid)
		else $error("dac valid did not follow rx valid");
	chk_dac_quiet: assert property (!rx_valid |=> !dac_valid && $stable(dac_right))
		else $error("dac changed without a receive sample");
	chk_dac_left: assert property (dac_valid && nl |-> dac_left == dl)
		else $error("dac left wrong");
	chk_dac_right: assert property (dac_valid && nr |-> dac_right == dr)
		else $error("dac right wrong");
	chk_map_error: assert property (psel && penable |-> pslverr == !mapped)
		else $error("slave error does not match address map");
endmodule // dmr_mix_router_monitor

bind dmr_mix_router dmr_mix_router_monitor #(.W(W)) u_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .mic_valid(mic_valid),
	.mic_left(mic_left), .mic_right(mic_right), .rx_valid(rx_valid), .rx_left(rx_left),
	.rx_right(rx_right), .tx_valid(tx_valid), .tx_left(tx_left), .tx_right(tx_right),
	.dac_valid(dac_valid), .dac_left(dac_left), .dac_right(dac_right)
);

// ===== dmr_pkg.sv
// Shared constants for the digital mixing and routing core.
// Assumes a 32-bit APB slave with one aligned word per register.
package dmr_pkg;

	// ==========================================================
	// Widths
	localparam int DATA_W = 24;
	localparam int REG_W  = 16;
	localparam int ADDR_W = 12;

	// ==========================================================
	// Register indices and byte addresses (address = index * 4)
	localparam logic [7:0] IDX_ROUTE    = 8'h18;
	localparam logic [7:0] IDX_SIDETONE = 8'h20;
	localparam logic [7:0] IDX_MICPOL   = 8'h26;
	localparam logic [7:0] IDX_STATUS   = 8'h30;
	localparam logic [ADDR_W-1:0] ADDR_ROUTE    = {2'h0, IDX_ROUTE, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_SIDETONE = {2'h0, IDX_SIDETONE, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_MICPOL   = {2'h0, IDX_MICPOL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = {2'h0, IDX_STATUS, 2'h0};

	// ==========================================================
	// Field positions
	localparam int ROUTE_RXL_INV  = 12;
	localparam int ROUTE_RXR_INV  = 11;
	localparam int ROUTE_BOOST_LO = 9;
	localparam int ROUTE_TXL_SRC  = 7;
	localparam int ROUTE_TXR_SRC  = 6;
	localparam int ROUTE_RXL_SRC  = 5;
	localparam int ROUTE_RXR_SRC  = 4;
	localparam int ST_LVL_L_LO    = 8;
	localparam int ST_LVL_R_LO    = 4;
	localparam int ST_SRC_L_LO    = 2;
	localparam int ST_SRC_R_LO    = 0;
	localparam int MIC_INV_L      = 1;
	localparam int MIC_INV_R      = 0;
	localparam int STAT_CLIP_L    = 0;
	localparam int STAT_CLIP_R    = 1;

	// ==========================================================
	// Reset values and writable bits
	localparam logic [REG_W-1:0] ROUTE_RESET    = 16'h0050;
	localparam logic [REG_W-1:0] SIDETONE_RESET = 16'h0000;
	localparam logic [REG_W-1:0] MICPOL_RESET   = 16'h0000;
	localparam logic [REG_W-1:0] ROUTE_MASK     = 16'h1ef0;
	localparam logic [REG_W-1:0] SIDETONE_MASK  = 16'h0fff;
	localparam logic [REG_W-1:0] MICPOL_MASK    = 16'h0003;
	localparam logic [1:0]       STATUS_RESET   = 2'h0;

	// ==========================================================
	// Sidetone source codes and level limit
	typedef enum logic [1:0] {
		DMR_ST_NONE  = 2'h0,
		DMR_ST_LEFT  = 2'h1,
		DMR_ST_RIGHT = 2'h2,
		DMR_ST_RSVD  = 2'h3
	} dmr_st_src_e;
	localparam logic [3:0] ST_LEVEL_TOP = 4'hc;
	localparam int         ST_GAIN_FRAC = 15;

endpackage

// ===== dmr_sat_negate.sv
// Conditional polarity flip of one signed sample with saturation.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module dmr_sat_negate #(
	parameter int W = 24
) (
	// Sample in and control
	input  wire logic signed [W-1:0] din,
	input  wire logic                flip,
	// Sample out
	output logic signed [W-1:0]      dout
);

	// ==========================================================
	// Negation: the most negative code maps to the most positive
	always_comb begin
		if (!flip) begin
			dout = din;
		end else if (din == {1'b1, {(W-1){1'b0}}}) begin
			dout = {1'b0, {(W-1){1'b1}}};
		end else begin
			dout = -din;
		end
	end

endmodule // dmr_sat_negate

// ===== dmr_sidetone_scale.sv
// Sidetone selection and level scaling for one converter path.
// Expects filtered microphone samples held stable by the caller.
`timescale 1ns/10ps
module dmr_sidetone_scale #(
	parameter int W = 24
) (
	// Filtered microphone samples
	input  wire logic signed [W-1:0] hpf_left,
	input  wire logic signed [W-1:0] hpf_right,
	// Controls
	input  wire logic [1:0]          source,
	input  wire logic [3:0]          level,
	// Scaled sidetone
	output logic signed [W-1:0]      tone
);

	logic signed [W-1:0]    picked;
	logic [15:0]            gain;
	logic signed [W+16:0]   product;

	// ==========================================================
	// Source pick; reserved code adds nothing
	always_comb begin
		unique case (dmr_pkg::dmr_st_src_e'(source))
			dmr_pkg::DMR_ST_LEFT:  picked = hpf_left;
			dmr_pkg::DMR_ST_RIGHT: picked = hpf_right;
			dmr_pkg::DMR_ST_NONE:  picked = '0;
			dmr_pkg::DMR_ST_RSVD:  picked = '0;
		endcase
	end

	// ==========================================================
	// Level code to linear gain, -36 dB to 0 dB in 3 dB steps
	always_comb begin
		unique case (level)
			4'h0:    gain = 16'h0207;
			4'h1:    gain = 16'h02de;
			4'h2:    gain = 16'h040c;
			4'h3:    gain = 16'h05b8;
			4'h4:    gain = 16'h0813;
			4'h5:    gain = 16'h0b68;
			4'h6:    gain = 16'h101d;
			4'h7:    gain = 16'h16c3;
			4'h8:    gain = 16'h2027;
			4'h9:    gain = 16'h2d6b;
			4'ha:    gain = 16'h4026;
			4'hb:    gain = 16'h5a9e;
			default: gain = 16'h8000;
		endcase
	end

	// Gain never exceeds unity, so the scaled sample fits W bits
	assign product = picked * $signed({1'b0, gain});
	assign tone    = product[W-1+dmr_pkg::ST_GAIN_FRAC:dmr_pkg::ST_GAIN_FRAC];

endmodule // dmr_sidetone_scale

// ===== testbench.sv
// Self-checking bench for the mixing and routing core.
// Drives APB and mic samples; the host model feeds receive data.
`timescale 1ns/10ps
module testbench;
	localparam int W = dmr_pkg::DATA_W;
	typedef logic signed [W-1:0] dmr_smp_t;
	localparam dmr_smp_t HL = 24'h400000;
	localparam dmr_smp_t HR = 24'hc00001;
	localparam dmr_smp_t RL = 24'h100000;
	localparam dmr_smp_t RR = 24'h800000;
	localparam dmr_smp_t RX = 24'h600000;
	logic		pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata;
	logic		mic_valid, hpf_valid, tx_valid, rx_valid, dac_valid, send;
	dmr_smp_t	mic_left, mic_right, hpf_left, hpf_right, tx_left, tx_right;
	dmr_smp_t	rx_left, rx_right, dac_left, dac_right, l_in, r_in;
	logic [2*W-1:0]	got;
	int		miscompares = 0;
	int		checks_done = 0;
	int		gain [16] = '{519, 734, 1036, 1464, 2067, 2920, 4125, 5827, 8231,
				11627, 16422, 23198, 32768, 32768, 32768, 32768};
	// ==========
	// Design and host
	dmr_mix_router dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mic_valid(mic_valid), .mic_left(mic_left), .mic_right(mic_right),
		.hpf_valid(hpf_valid), .hpf_left(hpf_left), .hpf_right(hpf_right),
		.tx_valid(tx_valid), .tx_left(tx_left), .tx_right(tx_right),
		.rx_valid(rx_valid), .rx_left(rx_left), .rx_right(rx_right),
		.dac_valid(dac_valid), .dac_left(dac_left), .dac_right(dac_right));
	dmr_host_model #(.W(W)) host (
		.pclk(pclk), .presetn(presetn), .send(send), .l_in(l_in), .r_in(r_in),
		.rx_valid(rx_valid), .rx_left(rx_left), .rx_right(rx_right),
		.tx_valid(tx_valid), .tx_left(tx_left), .tx_right(tx_right), .got(got));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ==========
	// Helpers
	function automatic dmr_smp_t sat(input longint v);
		if (v > 64'sh7fffff) return 24'h7fffff;
		if (v < -64'sh800000) return 24'h800000;
		return dmr_smp_t'(v);
	endfunction
	function automatic longint fl(input dmr_smp_t x, input logic f);
		return sat(f ? -longint'(x) : longint'(x));
	endfunction
	function automatic longint tone(input logic [1:0] s, input int v);
		if (s == 2'h1) return (longint'(HL) * gain[v]) >>> 15;
		if (s == 2'h2) return (longint'(HR) * gain[v]) >>> 15;
		return 0;
	endfunction
	task automatic cmp(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		cmp(q, x);
		cmp(e, xe);
	endtask
	// Bounded wait for a transmit or converter beat
	task automatic wait_out(input logic dac);
		int n;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while ((dac ? dac_valid : tx_valid) !== 1'b1 && n < 8);
		if ((dac ? dac_valid : tx_valid) !== 1'b1) begin
			miscompares++;
			$display("CHECK FAILED at %0t: no output beat", $time);
		end
	endtask
	task automatic rx_send(input dmr_smp_t l, input dmr_smp_t r);
		@(posedge pclk);
		send <= 1'b1;
		l_in <= l;
		r_in <= r;
		@(posedge pclk);
		send <= 1'b0;
		wait_out(1'b1);
	endtask
	// ==========
	// Scenarios
	task automatic t_regs();
		rd_chk(dmr_pkg::ADDR_ROUTE, 32'h00000050, 1'b0);
		rd_chk(dmr_pkg::ADDR_SIDETONE, 32'h0, 1'b0);
		rd_chk(dmr_pkg::ADDR_MICPOL, 32'h0, 1'b0);
		wr(dmr_pkg::ADDR_ROUTE, 32'hffffffff);
		rd_chk(dmr_pkg::ADDR_ROUTE, 32'h00001ef0, 1'b0);
		rd_chk(12'h004, 32'h0, 1'b1);
		$display("test regs done");
	endtask
	task automatic t_tx();
		dmr_smp_t el, er;
		for (int c = 0; c < 16; c++) begin
			wr(dmr_pkg::ADDR_ROUTE, {24'h0, c[0], c[1], 6'h0});
			wr(dmr_pkg::ADDR_MICPOL, {30'h0, c[3:2]});
			@(posedge pclk);
			mic_valid <= 1'b1;
			mic_left <= 24'h123456;
			mic_right <= RR;
			@(posedge pclk);
			mic_valid <= 1'b0;
			wait_out(1'b0);
			@(negedge pclk);
			el = sat(fl(c[0] ? RR : 24'h123456, c[0] ? c[2] : c[3]));
			er = sat(fl(c[1] ? RR : 24'h123456, c[1] ? c[2] : c[3]));
			cmp(got, {el, er});
		end
		$display("test tx done");
	endtask
	task automatic t_dac();
		dmr_smp_t el, er;
		for (int c = 0; c < 32; c++) begin
			wr(dmr_pkg::ADDR_ROUTE,
				{19'h0, c[4], c[4] ^ c[0], c[1:0], 3'h0, c[2], c[3], 4'h0});
			rx_send(RL, RR);
			el = sat(fl(c[2] ? RR : RL, c[4]) <<< c[1:0]);
			er = sat(fl(c[3] ? RR : RL, c[4] ^ c[0]) <<< c[1:0]);
			cmp({dac_left, dac_right}, {el, er});
		end
		// Boosted full-scale data clamps both paths and sets the sticky flags
		rd_chk(dmr_pkg::ADDR_STATUS, 32'h00000003, 1'b0);
		wr(dmr_pkg::ADDR_STATUS, 32'h00000003);
		rd_chk(dmr_pkg::ADDR_STATUS, 32'h0, 1'b0);
		$display("test dac done");
	endtask
	task automatic t_st();
		dmr_smp_t el, er;
		wr(dmr_pkg::ADDR_ROUTE, 32'h00000050);
		@(posedge pclk);
		hpf_valid <= 1'b1;
		hpf_left <= HL;
		hpf_right <= HR;
		mic_left <= 24'h7fffff;
		@(posedge pclk);
		hpf_valid <= 1'b0;
		for (int k = 0; k < 16; k++) begin
			wr(dmr_pkg::ADDR_SIDETONE, {20'h0, k[3:0], 4'(15 - k), k[1:0], k[3:2]});
			rx_send(RX, RX);
			el = sat(RX + tone(k[1:0], k));
			er = sat(RX + tone(k[3:2], 15 - k));
			cmp({dac_left, dac_right}, {el, er});
		end
		$display("test sidetone done");
	endtask
	// Reset in mid-run brings the route, sidetone and mic polarity registers back to their values after reset
	task automatic t_reset();
		wr(dmr_pkg::ADDR_ROUTE, 32'h00001ef0);
		wr(dmr_pkg::ADDR_MICPOL, 32'h00000003);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(dmr_pkg::ADDR_ROUTE, 32'h00000050, 1'b0);
		rd_chk(dmr_pkg::ADDR_SIDETONE, 32'h0, 1'b0);
		rd_chk(dmr_pkg::ADDR_MICPOL, 32'h0, 1'b0);
		$display("test reset done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#100000;
		miscompares++;
		$display("watchdog expired");
		report_and_stop();
	end
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, mic_valid, hpf_valid, send} = '0;
		{paddr, pwdata, mic_left, mic_right, hpf_left, hpf_right, l_in, r_in} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_tx();
		t_dac();
		t_st();
		t_reset();
		report_and_stop();
	end
endmodule // testbench
